// File: hw/pfc_consts.vh
// Constants for the period and frequency counter block
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH

// ----------------------------------------------------------------
// Register map (register indices, address bit positions and byte addresses)
// ----------------------------------------------------------------
`define PFC_CTR_STRIDE_LSB 4
`define PFC_REG_CTRL 2'h0
`define PFC_REG_DIVN 2'h1
`define PFC_REG_RESULT 2'h2
`define PFC_REG_STATUS 2'h3
`define PFC_ADDR_TBDIV 7'h40
`define PFC_ADDR_MSB 6

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define PFC_CTRL_MODE_LSB 0
`define PFC_CTRL_MODE_MSB 1
`define PFC_CTRL_GATE_FALL 2
`define PFC_CTRL_SRC_FALL 3
`define PFC_CTRL_GATE_SEL 4
`define PFC_CTRL_SRC_SEL 5
`define PFC_CTRL_ARM 7
`define PFC_CTRL_RW_MASK 32'h0000003F
`define PFC_DIVN_MASK 32'h0000FFFF

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define PFC_STAT_BUSY 0
`define PFC_STAT_DONE 1

// ----------------------------------------------------------------
// Measurement modes
// ----------------------------------------------------------------
`define PFC_MODE_PERIOD 2'h0
`define PFC_MODE_PULSE 2'h1
`define PFC_MODE_DIVIDE 2'h2

// ----------------------------------------------------------------
// Counter states
// ----------------------------------------------------------------
`define PFC_ST_IDLE 2'h0
`define PFC_ST_WAIT 2'h1
`define PFC_ST_COUNT 2'h2
`define PFC_ST_DONE 2'h3

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define PFC_CTRL_RST 6'h00
`define PFC_DIVN_RST 16'h0001
`define PFC_TBDIV_RST 16'h0009
`define PFC_ZERO32 32'h00000000
`define PFC_ONE32 32'h00000001
`define PFC_ZERO16 16'h0000
`define PFC_ONE16 16'h0001
`define PFC_HTRANS_NONSEQ_BIT 1

`endif

// File: hw/pfc_counter.v
// One measurement counter: period, pulse width or divide-down
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_counter (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Configuration and arm
	input wire arm,
	input wire [1:0] mode,
	input wire gate_fall,
	input wire [15:0] div_n,
	// Selected input events
	input wire gate_rise,
	input wire gate_drop,
	input wire gate_lvl,
	input wire src_ev,
	// Results
	output reg [31:0] result,
	output reg done,
	output wire busy,
	output reg pulse_out
);

reg [1:0] state;
reg [31:0] count;
wire gate_act_edge;
wire gate_end_edge;
wire [31:0] count_inc;
wire [31:0] div_n32;

// Active edge picked by configuration; a pulse ends as soon as the gate
// leaves its active level, the same cycle its closing edge is seen
assign gate_act_edge = gate_fall ? gate_drop : gate_rise;
assign gate_end_edge = gate_fall ? gate_lvl : !gate_lvl;
assign count_inc = count + `PFC_ONE32;
assign div_n32 = {16'h0000, div_n};
assign busy = (state == `PFC_ST_WAIT) || (state == `PFC_ST_COUNT);

// ----------------------------------------------------------------
// Measurement sequencer
// ----------------------------------------------------------------
// Arm is ignored in the cycle a measurement completes, so a result
// and its done flag can never be wiped by a racing arm.
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		state <= `PFC_ST_IDLE;
		count <= `PFC_ZERO32;
		result <= `PFC_ZERO32;
		done <= 1'b0;
		pulse_out <= 1'b0;
	end else begin
		case (state)
		`PFC_ST_WAIT: begin
			if (arm) begin
				count <= `PFC_ZERO32;
				pulse_out <= 1'b0;
			end else if (mode == `PFC_MODE_DIVIDE) begin
				if (src_ev) begin
					pulse_out <= 1'b1;
					count <= `PFC_ZERO32;
					state <= `PFC_ST_COUNT;
				end
			end else if (gate_act_edge) begin
				count <= `PFC_ZERO32;
				state <= `PFC_ST_COUNT;
			end
		end
		`PFC_ST_COUNT: begin
			if (mode == `PFC_MODE_DIVIDE) begin
				if (src_ev) begin
					count <= count_inc;
					if (count_inc >= div_n32) begin
						pulse_out <= 1'b0;
						result <= count_inc;
						done <= 1'b1;
						state <= `PFC_ST_DONE;
					end
				end else if (arm) begin
					count <= `PFC_ZERO32;
					pulse_out <= 1'b0;
					state <= `PFC_ST_WAIT;
				end
			end else if ((mode == `PFC_MODE_PULSE) ? gate_end_edge :
				gate_act_edge) begin
				result <= src_ev ? count_inc : count;
				done <= 1'b1;
				state <= `PFC_ST_DONE;
			end else if (arm) begin
				count <= `PFC_ZERO32;
				state <= `PFC_ST_WAIT;
			end else if (src_ev) begin
				count <= count_inc;
			end
		end
		`PFC_ST_IDLE, `PFC_ST_DONE: begin
			if (arm) begin
				count <= `PFC_ZERO32;
				done <= 1'b0;
				pulse_out <= 1'b0;
				state <= `PFC_ST_WAIT;
			end
		end
		default: begin
			state <= `PFC_ST_IDLE;
		end
		endcase
	end
end

endmodule

// File: hw/pfc_top.v
// Four-counter period and frequency measurement block, AHB-Lite slave
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_top (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Measurement pins, asynchronous to clk_sys
	input wire [3:0] gate_pin,
	input wire [3:0] measured_frequency,
	// Divide-down or gating pulse outputs
	output wire [3:0] ctr_out
);

// ----------------------------------------------------------------
// Configuration storage
// ----------------------------------------------------------------
reg [5:0] ctrl [0:3];
reg [15:0] div_n [0:3];
reg [15:0] tb_div;
reg [3:0] arm;

// ----------------------------------------------------------------
// Bus pipeline state
// ----------------------------------------------------------------
reg wr_pend;
reg [`PFC_ADDR_MSB:2] wr_addr;
reg [31:0] next_hrdata;
wire addr_phase;
wire [`PFC_ADDR_MSB:2] a_word;
wire [1:0] a_ctr;
wire [1:0] a_reg;
wire a_is_ctr;
wire fwd;

// ----------------------------------------------------------------
// Input synchronisers and timebase
// ----------------------------------------------------------------
reg [3:0] gate_s1;
reg [3:0] gate_s2;
reg [3:0] gate_s3;
reg [3:0] src_s1;
reg [3:0] src_s2;
reg [3:0] src_s3;
reg [3:0] out_d;
reg [15:0] tb_cnt;
reg known_reference_rate;

wire [31:0] res [0:3];
wire [3:0] done;
wire [3:0] busy;
wire [3:0] pulse_out;

assign ctr_out = pulse_out;

// Accepted address phase; only whole-word singles are expected
assign addr_phase = hsel && htrans[`PFC_HTRANS_NONSEQ_BIT] && hready;
assign a_word = haddr[`PFC_ADDR_MSB:2];
assign a_ctr = haddr[5:`PFC_CTR_STRIDE_LSB];
assign a_reg = haddr[3:2];
assign a_is_ctr = !haddr[`PFC_ADDR_MSB];
// A read right behind a write to the same word sees the new data
assign fwd = wr_pend && (wr_addr == a_word);

// Two flops on every pin; the third flop is only for edge detection
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		gate_s1 <= 4'h0;
		gate_s2 <= 4'h0;
		gate_s3 <= 4'h0;
		src_s1 <= 4'h0;
		src_s2 <= 4'h0;
		src_s3 <= 4'h0;
		out_d <= 4'h0;
	end else begin
		gate_s1 <= gate_pin;
		gate_s2 <= gate_s1;
		gate_s3 <= gate_s2;
		src_s1 <= measured_frequency;
		src_s2 <= src_s1;
		src_s3 <= src_s2;
		out_d <= pulse_out;
	end
end

// Internal known-rate tick, one clk_sys cycle every tb_div+1 cycles
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		tb_cnt <= `PFC_ZERO16;
		known_reference_rate <= 1'b0;
	end else if (tb_cnt >= tb_div) begin
		tb_cnt <= `PFC_ZERO16;
		known_reference_rate <= 1'b1;
	end else begin
		tb_cnt <= tb_cnt + `PFC_ONE16;
		known_reference_rate <= 1'b0;
	end
end

// ----------------------------------------------------------------
// Counter instances and routing
// ----------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_ctr
		wire g_lvl;
		wire g_rise;
		wire g_drop;
		wire s_ev;
		wire s_rise;
		wire s_drop;
		// gate from partner pulse or pin
		assign g_lvl = ctrl[gi][`PFC_CTRL_GATE_SEL] ? pulse_out[gi ^ 1] :
			gate_s2[gi];
		assign g_rise = ctrl[gi][`PFC_CTRL_GATE_SEL] ?
			(pulse_out[gi ^ 1] && !out_d[gi ^ 1]) :
			(gate_s2[gi] && !gate_s3[gi]);
		assign g_drop = ctrl[gi][`PFC_CTRL_GATE_SEL] ?
			(!pulse_out[gi ^ 1] && out_d[gi ^ 1]) :
			(!gate_s2[gi] && gate_s3[gi]);
		assign s_rise = src_s2[gi] && !src_s3[gi];
		assign s_drop = !src_s2[gi] && src_s3[gi];
		assign s_ev = ctrl[gi][`PFC_CTRL_SRC_SEL] ? known_reference_rate :
			(ctrl[gi][`PFC_CTRL_SRC_FALL] ? s_drop : s_rise);

		pfc_counter u_ctr (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.arm(arm[gi]),
			.mode(ctrl[gi][`PFC_CTRL_MODE_MSB:`PFC_CTRL_MODE_LSB]),
			.gate_fall(ctrl[gi][`PFC_CTRL_GATE_FALL]),
			.div_n(div_n[gi]),
			.gate_rise(g_rise),
			.gate_drop(g_drop),
			.gate_lvl(g_lvl),
			.src_ev(s_ev),
			.result(res[gi]),
			.done(done[gi]),
			.busy(busy[gi]),
			.pulse_out(pulse_out[gi])
		);
	end
endgenerate

// ----------------------------------------------------------------
// Register writes, in the data phase
// ----------------------------------------------------------------
integer i;
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		wr_pend <= 1'b0;
		wr_addr <= 5'h00;
		arm <= 4'h0;
		tb_div <= `PFC_TBDIV_RST;
		for (i = 0; i < 4; i = i + 1) begin
			ctrl[i] <= `PFC_CTRL_RST;
			div_n[i] <= `PFC_DIVN_RST;
		end
	end else begin
		wr_pend <= addr_phase && hwrite;
		wr_addr <= a_word;
		arm <= 4'h0;
		if (wr_pend) begin
			if (!wr_addr[`PFC_ADDR_MSB]) begin
				case (wr_addr[3:2])
				`PFC_REG_CTRL: begin
					ctrl[wr_addr[5:4]] <= hwdata[5:0];
					// Arm bit is a strobe and never stored
					arm[wr_addr[5:4]] <= hwdata[`PFC_CTRL_ARM];
				end
				`PFC_REG_DIVN: begin
					div_n[wr_addr[5:4]] <= hwdata[15:0];
				end
				default: begin
				end
				endcase
			end else if ({wr_addr, 2'b00} == `PFC_ADDR_TBDIV) begin
				tb_div <= hwdata[15:0];
			end
		end
	end
end

// ----------------------------------------------------------------
// Read mux, sampled at the address phase for a zero-wait answer
// ----------------------------------------------------------------
always @* begin
	next_hrdata = `PFC_ZERO32;
	if (a_is_ctr) begin
		case (a_reg)
		`PFC_REG_CTRL: begin
			next_hrdata = fwd ? (hwdata & `PFC_CTRL_RW_MASK) :
				{26'h0000000, ctrl[a_ctr]};
		end
		`PFC_REG_DIVN: begin
			next_hrdata = fwd ? (hwdata & `PFC_DIVN_MASK) :
				{16'h0000, div_n[a_ctr]};
		end
		`PFC_REG_RESULT: begin
			next_hrdata = res[a_ctr];
		end
		default: begin
			next_hrdata[`PFC_STAT_BUSY] = busy[a_ctr];
			next_hrdata[`PFC_STAT_DONE] = done[a_ctr];
		end
		endcase
	end else if ({a_word, 2'b00} == `PFC_ADDR_TBDIV) begin
		next_hrdata = fwd ? (hwdata & `PFC_DIVN_MASK) : {16'h0000, tb_div};
	end
end

// Never waits, always OKAY; unmapped reads return zero
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		hrdata <= `PFC_ZERO32;
		hreadyout <= 1'b0;
		hresp <= 1'b0;
	end else begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		if (addr_phase && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end
end

endmodule

// File: dv/pfc_properties.sv
// Bus-side checker for the period and frequency counter block
`timescale 1ns/1ps
module pfc_properties (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Register bus
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp
);
	wire rd;
	// Accepted read address phase
	assign rd = hsel && htrans[1] && hready && !hwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	okay_resp_a:
		assert property (hresp == 1'h0) else $error("bad response");
	ready_high_a:
		assert property ($past(rst_n) |-> hreadyout)
			else $error("wait state seen");
	rdata_hold_a:
		assert property (!rd |=> $stable(hrdata))
			else $error("read data moved");
	unmapped_zero_a:
		assert property (rd && haddr[6] && haddr[5:2] != 4'h0
			|=> hrdata == 32'h0) else $error("unmapped read");
	ctrl_bits_a:
		assert property (rd && !haddr[6] && haddr[3:2] == 2'h0
			|=> hrdata[31:6] == 26'h0) else $error("arm read back");
	div_bits_a:
		assert property (rd && !haddr[6] && haddr[3:2] == 2'h1
			|=> hrdata[31:16] == 16'h0) else $error("divisor width");
	tb_bits_a:
		assert property (rd && haddr[6:2] == 5'h10
			|=> hrdata[31:16] == 16'h0) else $error("timebase width");
	status_excl_a:
		assert property (rd && !haddr[6] && haddr[3:2] == 2'h3
			|=> hrdata[31:2] == 30'h0 && hrdata[1:0] != 2'h3)
			else $error("busy and done");
endmodule

bind pfc_top pfc_properties i_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.hsel(hsel),
	.haddr(haddr),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hrdata(hrdata),
	.hreadyout(hreadyout),
	.hresp(hresp)
);

// File: dv/pfc_sig_model.sv
// Periodic gate and source signals under measurement
`timescale 1ns/1ps
module pfc_sig_model (
	// Full gate period and source half period, in clock cycles
	input wire [15:0] gp,
	input wire [15:0] sh,
	// Pin levels
	output logic gate,
	output logic src
);
	// Offset from clock edges so pin sampling never races
	initial begin
		gate = 1'h0;
		src = 1'h0;
		#37;
		fork
			forever #(gp * 50) gate = ~gate;
			forever #(sh * 100) src = ~src;
		join
	end
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the period and frequency counter block
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] sh = 16'h0002;
	logic [31:0] rv;
	wire [31:0] hrdata;
	wire hreadyout;
	wire hresp;
	wire [3:0] ctr_out;
	wire g;
	wire s;
	int bad_count = 0;
	int compares = 0;

	// 10 MHz system clock
	always #50 clk_sys = ~clk_sys;

	pfc_sig_model i_sig (.gp(16'h0018), .sh(sh), .gate(g), .src(s));

	pfc_top i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .gate_pin({4{g}}), .measured_frequency({4{s}}),
		.ctr_out(ctr_out)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input string n, input logic [31:0] v, input logic [31:0] e);
		begin
			compares++;
			if (v !== e) begin
				bad_count++;
				$display("Error %s expected %h seen %h", n, e, v);
			end
		end
	endtask

	// One single transfer; the wait on ready is the bus handshake
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		begin
			@(posedge clk_sys);
			hsel <= 1'h1;
			htrans <= 2'h2;
			haddr <= a;
			hwrite <= w;
			@(posedge clk_sys);
			while (hreadyout !== 1'h1) @(posedge clk_sys);
			hsel <= 1'h0;
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge clk_sys);
			while (hreadyout !== 1'h1) @(posedge clk_sys);
			rv = hrdata;
		end
	endtask

	// Poll status until done; it must then read done without busy
	task wait_done(input logic [31:0] a);
		int i;
		begin
			i = 0;
			rv = 32'h0;
			while (rv[1] !== 1'h1 && i < 200) begin
				xfer(1'h0, a + 32'hC, 32'h0);
				i++;
			end
			chk("status", rv, 32'h2);
		end
	endtask

	task wrap_up;
		begin
			$display("mismatches %0d compares %0d", bad_count, compares);
			if (bad_count == 0 && compares > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		logic [31:0] ra [6];
		logic [31:0] ea [6];
		begin
			ra = '{32'h0, 32'h4, 32'h40, 32'h8, 32'hC, 32'h44};
			ea = '{32'h0, 32'h1, 32'h9, 32'h0, 32'h0, 32'h0};
			xfer(1'h1, 32'h8, 32'hFFFFFFFF);
			for (int i = 0; i < 6; i++) begin
				xfer(1'h0, ra[i], 32'h0);
				chk("reset value", rv, ea[i]);
			end
		end
	endtask

	// Gate running but no arm, then edge and timebase settings
	task t_period;
		logic [31:0] e;
		begin
			xfer(1'h1, 32'h40, 32'h0);
			xfer(1'h1, 32'h0, 32'h20);
			repeat (60) @(posedge clk_sys);
			xfer(1'h0, 32'hC, 32'h0);
			chk("unarmed status", rv, 32'h0);
			for (int k = 0; k < 4; k++) begin
				xfer(1'h1, 32'h40, k[1] ? 32'h2 : 32'h0);
				xfer(1'h1, 32'h0, k[0] ? 32'hA4 : 32'hA0);
				wait_done(32'h0);
				e = k[1] ? 32'h8 : 32'h18;
				xfer(1'h0, 32'h8, 32'h0);
				chk("period count", rv, e);
			end
			repeat (60) @(posedge clk_sys);
			xfer(1'h0, 32'h8, 32'h0);
			chk("held count", rv, e);
			xfer(1'h1, 32'h0, 32'hA0);
			xfer(1'h0, 32'hC, 32'h0);
			chk("rearmed status", rv, 32'h1);
			wait_done(32'h0);
		end
	endtask

	// Pin source, rising then falling edges counted
	task t_pin;
		begin
			xfer(1'h1, 32'h0, 32'h80);
			wait_done(32'h0);
			xfer(1'h0, 32'h8, 32'h0);
			chk("pin rise count", rv, 32'h6);
			xfer(1'h1, 32'h0, 32'h88);
			wait_done(32'h0);
			xfer(1'h0, 32'h8, 32'h0);
			chk("pin fall count", rv, 32'h6);
		end
	endtask

	// Counter 0 divides by 5, counter 1 times the window
	task t_wide(input logic [15:0] h);
		logic [31:0] w;
		begin
			sh <= h;
			repeat (20) @(posedge clk_sys);
			w = 32'd10 * h;
			xfer(1'h1, 32'h40, 32'h0);
			xfer(1'h1, 32'h4, 32'h5);
			xfer(1'h1, 32'h10, 32'hB1);
			xfer(1'h1, 32'h0, 32'h82);
			wait_done(32'h10);
			wait_done(32'h0);
			xfer(1'h0, 32'h8, 32'h0);
			chk("divide count", rv, 32'h5);
			xfer(1'h0, 32'h18, 32'h0);
			chk("window ok", rv >= w - 1 && rv <= w + 1, 32'h1);
		end
	endtask

	// Counter 3 makes a 40-cycle gate, counter 2 counts the pin
	task t_hifreq;
		begin
			sh <= 16'h0002;
			repeat (20) @(posedge clk_sys);
			xfer(1'h1, 32'h34, 32'h28);
			xfer(1'h1, 32'h20, 32'h91);
			xfer(1'h1, 32'h30, 32'hA2);
			repeat (10) @(posedge clk_sys);
			chk("gate pulse", ctr_out, 32'h8);
			wait_done(32'h30);
			wait_done(32'h20);
			chk("gate closed", ctr_out, 32'h0);
			xfer(1'h0, 32'h38, 32'h0);
			chk("gate width", rv, 32'h28);
			xfer(1'h0, 32'h28, 32'h0);
			chk("edges ok", rv >= 32'h9 && rv <= 32'hB, 32'h1);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk_sys);
		t_reset;
		t_period;
		t_pin;
		t_wide(16'h0002);
		t_wide(16'h0003);
		t_hifreq;
		wrap_up;
	end

	// Whole run needs under a thousand cycles; allow thirty times that
	initial begin
		#3000000;
		bad_count++;
		wrap_up;
	end
endmodule
